// File: bms_boot_mode_selector.sv
`timescale 1ns/1ps
// Function
// - Every reset starts in loader start-up logic; user code waits for it.
// - Two external resets within 750 ms enter loader mode; a command holds it.
// - A single external reset runs user program after 750 ms.
// - Loader exits to user program after 8 s without commands.
// - Loader owns top 4 KB; user gets lower 28 KB; no self-overwrite.
// - Brown-out enabled: supply below 4.3 V forces a reset.
// - Brown-out cause flag kept intact; user program clears it by zero.
// - Loader presents one virtual serial port taking programming commands.
// - USB works only in device role, never as host.
module bms_boot_mode_selector
    import bms_pkg::*;
#(
    parameter longint unsigned WINDOW_CYC = bms_pkg::DBL_WINDOW_CYC,
    parameter longint unsigned TIMEOUT_CYC = bms_pkg::LOADER_TMO_CYC
) (
    // Clock, reset, enable
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    input  wire logic                        ce_in,
    // External reset pin, active low
    input  wire logic                        ext_rst_n_in,
    // Supply monitor and watchdog reset request
    input  wire logic                        bod_enable_in,
    input  wire logic                        supply_low_in,
    input  wire logic                        wdog_rst_in,
    // Loader serial port activity
    input  wire logic                        cmd_rx_valid_in,
    // Loader flash write requests
    input  wire logic                        flash_wr_req_in,
    input  wire logic [bms_pkg::ADDR_W-1:0]  flash_wr_addr_in,
    // User program cause register access
    input  wire logic                        cause_clr_in,
    // Outputs
    output logic                             core_rst_out,
    output logic                             loader_mode_out,
    output logic                             user_run_out,
    output logic                             serial_port_en_out,
    output logic                             usb_device_role_out,
    output logic                             usb_host_en_out,
    output logic                             flash_wr_ok_out,
    output logic [bms_pkg::CAUSE_W-1:0]      cause_out
);
    import bms_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchroniser and supply monitor
    // ------------------------------------------------------------------
    logic [2:0] pin_sync_reg, pin_sync_next;
    logic       pin_n_reg, pin_n_next;
    logic [2:0] bod_sync_reg, bod_sync_next;
    logic       bod_reg, bod_next;

    always_comb begin
        pin_sync_next = {pin_sync_reg[1:0], ext_rst_n_in};
        bod_sync_next = {bod_sync_reg[1:0], supply_low_in};
        pin_n_next = pin_n_reg;
        bod_next   = bod_reg;
        if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_n_next = pin_sync_reg[2];
        end
        if (bod_sync_reg[1] == bod_sync_reg[2]) begin
            bod_next = bod_sync_reg[2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pin_sync_reg <= 3'h7;
            pin_n_reg    <= 1'b1;
            bod_sync_reg <= 3'h0;
            bod_reg      <= 1'b0;
        end else if (ce_in) begin
            pin_sync_reg <= pin_sync_next;
            pin_n_reg    <= pin_n_next;
            bod_sync_reg <= bod_sync_next;
            bod_reg      <= bod_next;
        end
    end

    logic bod_trip;
    logic ext_hold;
    assign bod_trip = bod_enable_in & bod_reg;
    assign ext_hold = ~pin_n_reg;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    bms_state_t           state_reg, state_next;
    logic [CNT_W-1:0]     cnt_reg, cnt_next;
    logic                 armed_reg, armed_next;
    logic                 ext_seen_reg, ext_seen_next;
    logic                 rst_any;

    assign rst_any = ext_hold | bod_trip | wdog_rst_in;

    // True in the last cycle of a span counted from zero
    function automatic logic cnt_done(input logic [CNT_W-1:0] cnt,
                                      input longint unsigned  span);
        return cnt >= CNT_W'(span - 1);
    endfunction : cnt_done

    // START picks loader or wait; WAIT times the second-press window
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        armed_next    = armed_reg;
        ext_seen_next = ext_seen_reg;
        if (rst_any) begin
            // Any reset returns to loader start-up
            state_next    = BMS_ST_START;
            cnt_next      = '0;
            // Only a pin reset may count as the second press
            ext_seen_next = ext_seen_reg | ext_hold;
        end else begin
            unique case (state_reg)
                BMS_ST_START: begin
                    cnt_next      = '0;
                    ext_seen_next = 1'b0;
                    if (armed_reg && ext_seen_reg) begin
                        armed_next = 1'b0;
                        state_next = BMS_ST_LOADER;
                    end else begin
                        armed_next = 1'b1;
                        state_next = BMS_ST_WAIT;
                    end
                end
                BMS_ST_WAIT: begin
                    if (cnt_done(cnt_reg, WINDOW_CYC)) begin
                        armed_next = 1'b0;
                        state_next = BMS_ST_USER;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_reg + CNT_W'(1);
                    end
                end
                BMS_ST_LOADER: begin
                    if (cmd_rx_valid_in) begin
                        state_next = BMS_ST_PROG;
                    end else if (cnt_done(cnt_reg, TIMEOUT_CYC)) begin
                        state_next = BMS_ST_USER;
                        cnt_next   = '0;
                    end else begin
                        cnt_next = cnt_reg + CNT_W'(1);
                    end
                end
                BMS_ST_PROG: begin
                    state_next = BMS_ST_PROG;
                end
                BMS_ST_USER: begin
                    state_next = BMS_ST_USER;
                end
                default: begin
                    state_next = BMS_ST_START;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg    <= BMS_ST_START;
            cnt_reg      <= '0;
            armed_reg    <= 1'b0;
            ext_seen_reg <= 1'b0;
        end else if (ce_in) begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            armed_reg    <= armed_next;
            ext_seen_reg <= ext_seen_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset cause record
    // ------------------------------------------------------------------
    logic [CAUSE_W-1:0]   cause_reg, cause_next;

    // A cause raised in the cycle of a clear still survives
    always_comb begin
        cause_next = cause_reg;
        if (cause_clr_in) begin
            cause_next = '0;
        end
        if (ext_hold) begin
            cause_next[CAUSE_EXT] = 1'b1;
        end
        if (bod_trip) begin
            cause_next[CAUSE_BROWNOUT] = 1'b1;
        end
        if (wdog_rst_in) begin
            cause_next[CAUSE_WDOG] = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cause_reg <= CAUSE_RESET_VAL;
        end else if (ce_in) begin
            cause_reg <= cause_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic in_loader;
    assign in_loader = (state_reg == BMS_ST_LOADER) |
                       (state_reg == BMS_ST_PROG);

    assign core_rst_out        = rst_any;
    assign loader_mode_out     = in_loader;
    assign user_run_out        = (state_reg == BMS_ST_USER);
    assign serial_port_en_out  = in_loader;
    assign usb_device_role_out = 1'b1;
    assign usb_host_en_out     = 1'b0;
    assign cause_out           = cause_reg;
    assign flash_wr_ok_out     = flash_wr_req_in & in_loader &
                                 (flash_wr_addr_in < LOADER_BASE);
endmodule : bms_boot_mode_selector

// File: bms_pkg.sv
package bms_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned DBL_WINDOW_MS    = 750;
    localparam int unsigned LOADER_TMO_S     = 8;
    localparam longint unsigned DBL_WINDOW_CYC =
        longint'(CLK_HZ) / 1000 * DBL_WINDOW_MS;
    localparam longint unsigned LOADER_TMO_CYC =
        longint'(CLK_HZ) * LOADER_TMO_S;
    localparam int unsigned CNT_W = 32;

    // ------------------------------------------------------------------
    // Program memory map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W           = 15;
    localparam logic [14:0] USER_LIMIT_KB    = 15'h001c;
    localparam logic [14:0] LOADER_BASE      = 15'h7000;

    // ------------------------------------------------------------------
    // Reset cause bits
    // ------------------------------------------------------------------
    localparam int unsigned CAUSE_W          = 4;
    localparam int unsigned CAUSE_POWER      = 0;
    localparam int unsigned CAUSE_EXT        = 1;
    localparam int unsigned CAUSE_BROWNOUT   = 2;
    localparam int unsigned CAUSE_WDOG       = 3;
    localparam logic [3:0]  CAUSE_RESET_VAL  = 4'h1;

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BMS_ST_START   = 3'b000,
        BMS_ST_WAIT    = 3'b001,
        BMS_ST_LOADER  = 3'b010,
        BMS_ST_PROG    = 3'b011,
        BMS_ST_USER    = 3'b100
    } bms_state_t;
endpackage : bms_pkg

// File: bms_boot_mode_selector_assertions.sv
`timescale 1ns/1ps
module bms_boot_mode_selector_assertions
    import bms_pkg::*;
#(
    parameter longint unsigned WINDOW_CYC  = 20,
    parameter longint unsigned TIMEOUT_CYC = 50
) (
    // Watched ports
    input wire logic                        clk_in,
    input wire logic                        srst_in,
    input wire logic                        ce_in,
    input wire logic                        bod_enable_in,
    input wire logic                        supply_low_in,
    input wire logic                        wdog_rst_in,
    input wire logic                        cmd_rx_valid_in,
    input wire logic                        flash_wr_req_in,
    input wire logic [bms_pkg::ADDR_W-1:0]  flash_wr_addr_in,
    input wire logic                        cause_clr_in,
    input wire logic                        core_rst_out,
    input wire logic                        loader_mode_out,
    input wire logic                        user_run_out,
    input wire logic                        serial_port_en_out,
    input wire logic                        usb_host_en_out,
    input wire logic                        flash_wr_ok_out,
    input wire logic [bms_pkg::CAUSE_W-1:0] cause_out
);
    logic [31:0] wait_reg, wait_next, ldr_reg, ldr_next;
    // Cycles spent waiting for the user program, and spent in the loader
    always_comb begin
        wait_next = wait_reg + 32'h1;
        ldr_next  = ldr_reg + 32'h1;
        if (core_rst_out || user_run_out || loader_mode_out) wait_next = '0;
        if (!loader_mode_out) ldr_next = '0;
        if (!ce_in) begin
            wait_next = wait_reg;
            ldr_next  = ldr_reg;
        end
    end
    always_ff @(posedge clk_in) begin
        wait_reg <= srst_in ? '0 : wait_next;
        ldr_reg  <= srst_in ? '0 : ldr_next;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_cmd_taken;
        loader_mode_out && cmd_rx_valid_in && !core_rst_out;
    endsequence
    sequence s_loader_held;
        (loader_mode_out && !user_run_out)[*8];
    endsequence
    a_no_host_role: assert property (!usb_host_en_out)
        else $error("host role enabled");
    a_port_with_loader: assert property (
        serial_port_en_out == loader_mode_out)
        else $error("serial port not tied to loader mode");
    a_flash_top_guard: assert property (flash_wr_ok_out == (
        flash_wr_req_in && loader_mode_out &&
        flash_wr_addr_in < LOADER_BASE))
        else $error("flash write permission wrong");
    a_loader_first: assert property (ce_in && core_rst_out |=>
        !user_run_out && !loader_mode_out)
        else $error("run state during reset");
    a_brownout_reset: assert property (
        (ce_in && bod_enable_in && supply_low_in)[*6] |-> core_rst_out)
        else $error("no reset on low supply");
    a_wdog_reset: assert property (wdog_rst_in |-> core_rst_out)
        else $error("no reset on watchdog request");
    a_cause_kept: assert property ($fell(cause_out[CAUSE_BROWNOUT])
        |-> $past(cause_clr_in))
        else $error("brownout cause lost");
    a_single_wait: assert property ($rose(user_run_out) &&
        !$past(loader_mode_out) |-> wait_reg >= WINDOW_CYC
        && wait_reg <= WINDOW_CYC + 3)
        else $error("user start not after window");
    a_loader_timeout: assert property ($fell(loader_mode_out) &&
        !$past(core_rst_out) |-> ldr_reg + 1 >= TIMEOUT_CYC
        && ldr_reg <= TIMEOUT_CYC + 1)
        else $error("loader timeout length wrong");
    a_cmd_holds: assert property (s_cmd_taken |=> s_loader_held)
        else $error("loader left after command");
    a_freeze_hold: assert property (!ce_in |=>
        $stable(user_run_out) && $stable(loader_mode_out) &&
        $stable(cause_out))
        else $error("state moved while clock enable low");
endmodule : bms_boot_mode_selector_assertions

bind bms_boot_mode_selector bms_boot_mode_selector_assertions #(
    .WINDOW_CYC(WINDOW_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
    .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .bod_enable_in(bod_enable_in), .supply_low_in(supply_low_in),
    .wdog_rst_in(wdog_rst_in), .cmd_rx_valid_in(cmd_rx_valid_in),
    .flash_wr_req_in(flash_wr_req_in),
    .flash_wr_addr_in(flash_wr_addr_in), .cause_clr_in(cause_clr_in),
    .core_rst_out(core_rst_out), .loader_mode_out(loader_mode_out),
    .user_run_out(user_run_out), .serial_port_en_out(serial_port_en_out),
    .usb_host_en_out(usb_host_en_out), .flash_wr_ok_out(flash_wr_ok_out),
    .cause_out(cause_out));

// File: bms_host_pin_model.sv
`timescale 1ns/1ps
module bms_host_pin_model (
    // Clock
    input  wire logic clk_in,
    // Reset button and host command activity
    output logic      ext_rst_n_out,
    output logic      cmd_rx_valid_out
);
    // Pin has a pull-up, so it idles high
    initial begin
        ext_rst_n_out    = 1'b1;
        cmd_rx_valid_out = 1'b0;
    end
    task automatic press(input int n);
        @(negedge clk_in) ext_rst_n_out = 1'b0;
        repeat (n) @(negedge clk_in);
        ext_rst_n_out = 1'b1;
    endtask : press
    task automatic send_cmd();
        @(negedge clk_in) cmd_rx_valid_out = 1'b1;
        @(negedge clk_in) cmd_rx_valid_out = 1'b0;
    endtask : send_cmd
endmodule : bms_host_pin_model

// File: bms_boot_mode_selector_tb_top.sv
`timescale 1ns/1ps
module bms_boot_mode_selector_tb_top;
    import bms_pkg::*;
    localparam int     W = 20;
    localparam int     T = 50;
    logic              clk_in, srst_in, bod_en, sup_low, req, clr, ce, wdog;
    logic              rst_n, cmd, core_rst, ldr, user, wr_ok;
    logic              port_en, dev_role, host_en;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        cause, st, usb;
    int                bad_count = 0;
    int                num_checks = 0;
    assign st  = {core_rst, ldr, user, wr_ok};
    assign usb = {1'b0, port_en, dev_role, host_en};
    bms_boot_mode_selector #(.WINDOW_CYC(W), .TIMEOUT_CYC(T)) uut (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
        .ext_rst_n_in(rst_n), .bod_enable_in(bod_en), .supply_low_in(sup_low),
        .wdog_rst_in(wdog), .cmd_rx_valid_in(cmd), .flash_wr_req_in(req),
        .flash_wr_addr_in(addr), .cause_clr_in(clr), .core_rst_out(core_rst),
        .loader_mode_out(ldr), .user_run_out(user),
        .serial_port_en_out(port_en), .usb_device_role_out(dev_role),
        .usb_host_en_out(host_en), .flash_wr_ok_out(wr_ok),
        .cause_out(cause));
    bms_host_pin_model pm (.clk_in(clk_in), .ext_rst_n_out(rst_n),
        .cmd_rx_valid_out(cmd));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic chk(input string n, input logic [3:0] e, g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic t_single_and_late();
        pm.press(4);
        cyc(6);
        chk("st", 4'b0000, st);
        chk("cause", 4'h2, cause & 4'h2);
        cyc(W + 4);
        chk("st", 4'b0010, st);
        pm.press(4);
        cyc(6);
        chk("st", 4'b0000, st);
        cyc(W + 4);
        chk("st", 4'b0010, st);
    endtask : t_single_and_late
    task automatic t_double(input logic send);
        pm.press(4);
        cyc(5);
        pm.press(4);
        cyc(8);
        chk("st", 4'b0100, st);
        chk("usb", 4'b0110, usb);
        if (send) pm.send_cmd();
        {req, addr} = {1'b1, 15'h6fff};
        #1 chk("st", 4'b0101, st);
        cyc(1);
        addr = 15'h7000;
        #1 chk("st", 4'b0100, st);
        cyc(1);
        req = 1'b0;
        cyc(T + 10);
        chk("st", send ? 4'b0100 : 4'b0010, st);
        chk("usb", send ? 4'b0110 : 4'b0010, usb);
        req = 1'b1;
        #1 chk("st", send ? 4'b0100 : 4'b0010, st);
        cyc(1);
        req = 1'b0;
    endtask : t_double
    task automatic t_brownout();
        {bod_en, sup_low} = 2'b11;
        cyc(8);
        chk("st", 4'b1000, st);
        sup_low = 1'b0;
        cyc(6);
        chk("cause", 4'h4, cause & 4'h4);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(2);
        chk("cause", 4'h0, cause & 4'h4);
        {bod_en, sup_low} = 2'b01;
        cyc(8);
        chk("st", 4'b0000, st & 4'b1000);
        sup_low = 1'b0;
    endtask : t_brownout
    task automatic t_wdog_freeze();
        cyc(W + 4);
        chk("st", 4'b0010, st);
        wdog = 1'b1;
        #1 chk("st", 4'b1010, st);
        cyc(1);
        wdog = 1'b0;
        cyc(1);
        chk("st", 4'b0000, st);
        chk("cause", 4'h8, cause & 4'h8);
        ce = 1'b0;
        cyc(W + 10);
        chk("st", 4'b0000, st);
        ce = 1'b1;
        cyc(W + 4);
        chk("st", 4'b0010, st);
    endtask : t_wdog_freeze
    initial begin
        {srst_in, bod_en, sup_low, req, clr, wdog} = 6'b100000;
        ce   = 1'b1;
        addr = '0;
        cyc(16);
        srst_in = 1'b0;
        cyc(2);
        chk("st", 4'b0000, st);
        chk("cause", CAUSE_RESET_VAL, cause);
        cyc(W + 5);
        chk("st", 4'b0010, st);
        chk("usb", 4'b0010, usb);
        t_single_and_late();
        t_double(1'b0);
        t_double(1'b1);
        t_brownout();
        t_wdog_freeze();
        tally_and_finish();
    end
    // Whole run is near 400 cycles
    initial begin
        #(5 * 5000);
        bad_count++;
        tally_and_finish();
    end
endmodule : bms_boot_mode_selector_tb_top
